// ==== hw/vout_cfg_pkg.sv ====
// constants of the virtual output configuration bank
// ------------------------------------------------------------
// Overview of operation
// R1: function select takes codes 0 to 99
// R2: eighteen outputs: 1 to 16, 20, 21
// R3: settings writable anytime, immediate, reset to 0
// R4: read-only word holds levels of outputs 1-16
// R5: separate read-only word holds levels 20, 21
// R6: polarity 0 drives 1, 1 drives 0 when asserted
// R7: reported level is function state after polarity
// ------------------------------------------------------------
package vout_cfg_pkg;
	// channel 0..15 are outputs 1..16, 16 is output 20, 17 is output 21
	localparam int          NUM_CH     = 18;
	localparam int          CH_W       = 5;
	localparam int          FSEL_W     = 7;
	localparam int          REG_W      = 16;
	localparam int          FUNC_MAX   = 99;
	localparam int          ADDR_W     = 12;
	// byte addresses of the register map
	localparam logic [11:0] FN_BASE    = 12'h000;
	localparam logic [11:0] POL_BASE   = 12'h080;
	localparam logic [11:0] LVL_LO_ADR = 12'h100;
	localparam logic [11:0] LVL_HI_ADR = 12'h104;
	localparam int          GRP_MSB    = 11;
	localparam int          GRP_LSB    = 7;
	localparam int          IDX_MSB    = 6;
	localparam int          IDX_LSB    = 2;
	localparam logic [4:0]  GRP_FN     = 5'h00;
	localparam logic [4:0]  GRP_POL    = 5'h01;
	// reset values
	localparam logic [6:0]  FSEL_RST   = 7'h00;
	localparam logic        POL_RST    = 1'b0;
	// bus answers
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	localparam logic [1:0]  RESP_DEC   = 2'h3;
endpackage

// ==== hw/vout_cfg_bank.sv ====
// register bank and level logic of the virtual digital outputs
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module vout_cfg_bank #(
	parameter int NUM_FUNC = 100
) (
	input  wire logic                      CLK_SYS,
	input  wire logic                      RST,
	input  wire logic [NUM_FUNC-1:0]       FUNC_STATE,
	output logic [vout_cfg_pkg::NUM_CH-1:0] VIRTUAL_OUTPUT_LEVEL,
	input  wire logic [11:0]               S_AXI_AWADDR,
	input  wire logic                      S_AXI_AWVALID,
	output logic                           S_AXI_AWREADY,
	input  wire logic [31:0]               S_AXI_WDATA,
	input  wire logic [3:0]                S_AXI_WSTRB,
	input  wire logic                      S_AXI_WVALID,
	output logic                           S_AXI_WREADY,
	output logic [1:0]                     S_AXI_BRESP,
	output logic                           S_AXI_BVALID,
	input  wire logic                      S_AXI_BREADY,
	input  wire logic [11:0]               S_AXI_ARADDR,
	input  wire logic                      S_AXI_ARVALID,
	output logic                           S_AXI_ARREADY,
	output logic [31:0]                    S_AXI_RDATA,
	output logic [1:0]                     S_AXI_RRESP,
	output logic                           S_AXI_RVALID,
	input  wire logic                      S_AXI_RREADY
);
	localparam int N = vout_cfg_pkg::NUM_CH;

	// every code 0..99 must name an existing function input
	if (NUM_FUNC < vout_cfg_pkg::FUNC_MAX + 1) begin : g_chk
		$error("NUM_FUNC too small for function codes");
	end

	// ------------------------------------------------------------
	// write channel holding
	// ------------------------------------------------------------
	logic        aw_held_q, aw_held_d;
	logic [11:0] aw_addr_q, aw_addr_d;
	logic        w_held_q, w_held_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic        awready_q, awready_d;
	logic        wready_q, wready_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        commit;

	// address and data are taken in either order; commit waits for both and a free response slot
	assign commit = aw_held_q && w_held_q && !bvalid_q;

	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		if (commit) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
		end
		if (S_AXI_AWVALID && awready_q) begin
			aw_held_d = 1'b1;
			aw_addr_d = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wready_q) begin
			w_held_d = 1'b1;
			w_data_d = S_AXI_WDATA;
			w_strb_d = S_AXI_WSTRB;
		end
		awready_d = !aw_held_d;
		wready_d  = !w_held_d;
	end

	// ------------------------------------------------------------
	// settings storage
	// ------------------------------------------------------------
	logic [6:0]  fsel_q [N];
	logic [6:0]  fsel_d [N];
	logic [N-1:0] pol_q, pol_d;
	logic [4:0]  wr_grp, wr_idx;
	logic [15:0] fn_merged;

	assign wr_grp = aw_addr_q[vout_cfg_pkg::GRP_MSB:vout_cfg_pkg::GRP_LSB];
	assign wr_idx = aw_addr_q[vout_cfg_pkg::IDX_MSB:vout_cfg_pkg::IDX_LSB];

	// settings change on a write to a function or polarity register (polarity only with lane 0), in the cycle after commit; out-of-range codes keep the old value
	always_comb begin
		fsel_d    = fsel_q;
		pol_d     = pol_q;
		bvalid_d  = bvalid_q && !S_AXI_BREADY;
		bresp_d   = bresp_q;
		fn_merged = 16'h0000;
		if (wr_idx < 5'(N)) begin
			fn_merged = {9'h000, fsel_q[wr_idx]};
		end
		if (w_strb_q[0]) begin
			fn_merged[7:0] = w_data_q[7:0];
		end
		if (w_strb_q[1]) begin
			fn_merged[15:8] = w_data_q[15:8];
		end
		if (commit) begin
			bvalid_d = 1'b1;
			bresp_d  = vout_cfg_pkg::RESP_OKAY;
			if (aw_addr_q[1:0] != 2'h0 || wr_idx >= 5'(N)) begin
				bresp_d = vout_cfg_pkg::RESP_DEC;
			end else if (wr_grp == vout_cfg_pkg::GRP_FN) begin
				if (fn_merged <= 16'(vout_cfg_pkg::FUNC_MAX)) begin
					fsel_d[wr_idx] = fn_merged[6:0]; // R1 R3
				end else begin
					bresp_d = vout_cfg_pkg::RESP_SLV;
				end
			end else if (wr_grp == vout_cfg_pkg::GRP_POL) begin
				if (w_strb_q[0]) begin
					pol_d[wr_idx] = w_data_q[0]; // R3 R6
				end
			end else if (aw_addr_q == vout_cfg_pkg::LVL_LO_ADR || aw_addr_q == vout_cfg_pkg::LVL_HI_ADR) begin
				bresp_d = vout_cfg_pkg::RESP_SLV;
			end else begin
				bresp_d = vout_cfg_pkg::RESP_DEC;
			end
		end
	end

	// ------------------------------------------------------------
	// level computation, one slice per output
	// ------------------------------------------------------------
	logic [N-1:0] chosen;
	logic [N-1:0] lvl_q, lvl_d;

	for (genvar i = 0; i < N; i++) begin : g_ch
		// stored codes never exceed 99, so the index stays inside FUNC_STATE
		assign chosen[i] = FUNC_STATE[fsel_q[i]];
		assign lvl_d[i]  = chosen[i] ^ pol_q[i]; // R6 R7

		AST_FUNC_RANGE: assert property (@(posedge CLK_SYS) disable iff (RST) // R1
			fsel_q[i] <= 7'(vout_cfg_pkg::FUNC_MAX))
			else $error("function code above 99");
		AST_LEVEL_AFTER_POL: assert property (@(posedge CLK_SYS) disable iff (RST) // R7
			1'b1 |=> lvl_q[i] == ($past(chosen[i]) ^ $past(pol_q[i])))
			else $error("level is not function state after polarity");
		AST_POL_ACTIVE_LOW: assert property (@(posedge CLK_SYS) disable iff (RST) // R6
			(chosen[i] && pol_q[i]) |=> !lvl_q[i])
			else $error("inverted output not low while asserted");
		AST_POL_ACTIVE_HIGH: assert property (@(posedge CLK_SYS) disable iff (RST) // R6
			(chosen[i] && !pol_q[i]) |=> lvl_q[i])
			else $error("plain output not high while asserted");
		AST_RESET_DEFAULT: assert property (@(posedge CLK_SYS) // R3
			($past(RST) && !RST) |-> (fsel_q[i] == vout_cfg_pkg::FSEL_RST && pol_q[i] == vout_cfg_pkg::POL_RST))
			else $error("setting not zero after reset");
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	logic        arready_q, arready_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [4:0]  rd_grp, rd_idx;

	assign rd_grp = S_AXI_ARADDR[vout_cfg_pkg::GRP_MSB:vout_cfg_pkg::GRP_LSB];
	assign rd_idx = S_AXI_ARADDR[vout_cfg_pkg::IDX_MSB:vout_cfg_pkg::IDX_LSB];

	// one read at a time; the answer comes the cycle after the address is taken
	always_comb begin
		rvalid_d = rvalid_q && !S_AXI_RREADY;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (S_AXI_ARVALID && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d  = 32'h0000_0000;
			rresp_d  = vout_cfg_pkg::RESP_OKAY;
			if (S_AXI_ARADDR == vout_cfg_pkg::LVL_LO_ADR) begin
				rdata_d[15:0] = lvl_q[15:0]; // R4
			end else if (S_AXI_ARADDR == vout_cfg_pkg::LVL_HI_ADR) begin
				rdata_d[1:0] = lvl_q[N-1:16]; // R5
			end else if (S_AXI_ARADDR[1:0] != 2'h0 || rd_idx >= 5'(N)) begin
				rresp_d = vout_cfg_pkg::RESP_DEC;
			end else if (rd_grp == vout_cfg_pkg::GRP_FN) begin
				rdata_d[6:0] = fsel_q[rd_idx]; // R2
			end else if (rd_grp == vout_cfg_pkg::GRP_POL) begin
				rdata_d[0] = pol_q[rd_idx];
			end else begin
				rresp_d = vout_cfg_pkg::RESP_DEC;
			end
		end
		arready_d = !rvalid_d;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= vout_cfg_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= vout_cfg_pkg::RESP_OKAY;
			pol_q     <= '0; // R3
			lvl_q     <= '0;
			for (int k = 0; k < N; k++) begin
				fsel_q[k] <= vout_cfg_pkg::FSEL_RST; // R3
			end
		end else begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			pol_q     <= pol_d;
			lvl_q     <= lvl_d;
			fsel_q    <= fsel_d;
		end
	end

	assign S_AXI_AWREADY        = awready_q;
	assign S_AXI_WREADY         = wready_q;
	assign S_AXI_BVALID         = bvalid_q;
	assign S_AXI_BRESP          = bresp_q;
	assign S_AXI_ARREADY        = arready_q;
	assign S_AXI_RVALID         = rvalid_q;
	assign S_AXI_RDATA          = rdata_q;
	assign S_AXI_RRESP          = rresp_q;
	assign VIRTUAL_OUTPUT_LEVEL = lvl_q;

	// ------------------------------------------------------------
	// checks on the bus side
	// ------------------------------------------------------------
	sequence s_rd(logic [11:0] a);
		S_AXI_ARVALID && arready_q && S_AXI_ARADDR == a;
	endsequence

	sequence s_fn_wr;
		commit && wr_grp == vout_cfg_pkg::GRP_FN && wr_idx < 5'(N) && aw_addr_q[1:0] == 2'h0
			&& fn_merged <= 16'(vout_cfg_pkg::FUNC_MAX);
	endsequence

	// a code above the range, which must leave the setting alone
	sequence s_fn_bad;
		commit && wr_grp == vout_cfg_pkg::GRP_FN && wr_idx < 5'(N) && aw_addr_q[1:0] == 2'h0
			&& fn_merged > 16'(vout_cfg_pkg::FUNC_MAX);
	endsequence

	// a polarity write whose low byte lane is enabled
	sequence s_pol_wr;
		commit && wr_grp == vout_cfg_pkg::GRP_POL && wr_idx < 5'(N) && aw_addr_q[1:0] == 2'h0
			&& w_strb_q[0];
	endsequence

	// the setting and the write answer both appear in the cycle after commit
	AST_WRITE_IMMEDIATE: assert property (@(posedge CLK_SYS) disable iff (RST) // R3
		s_fn_wr |=> fsel_q[$past(wr_idx)] == $past(fn_merged[6:0]) && bvalid_q)
		else $error("function write not applied at once");
	AST_LOW_WORD: assert property (@(posedge CLK_SYS) disable iff (RST) // R4
		s_rd(vout_cfg_pkg::LVL_LO_ADR) |=> S_AXI_RVALID && S_AXI_RDATA == {16'h0000, $past(lvl_q[15:0])})
		else $error("levels 1-16 word wrong");
	AST_HIGH_WORD: assert property (@(posedge CLK_SYS) disable iff (RST) // R5
		s_rd(vout_cfg_pkg::LVL_HI_ADR) |=> S_AXI_RVALID && S_AXI_RDATA == {30'h0, $past(lvl_q[17:16])})
		else $error("levels 20-21 word wrong");
	AST_LAST_CHANNEL: assert property (@(posedge CLK_SYS) disable iff (RST) // R2
		s_rd(12'h044) |=> S_AXI_RVALID && S_AXI_RRESP == vout_cfg_pkg::RESP_OKAY)
		else $error("output 21 function register missing");

	// a refused code is answered as a slave error and stored nowhere
	AST_CODE_REFUSED: assert property (@(posedge CLK_SYS) disable iff (RST) // R1
		s_fn_bad |=> fsel_q[$past(wr_idx)] == $past(fsel_q[wr_idx]) && bresp_q == vout_cfg_pkg::RESP_SLV)
		else $error("out of range code was stored");
	AST_POL_WRITE: assert property (@(posedge CLK_SYS) disable iff (RST) // R6
		s_pol_wr |=> pol_q[$past(wr_idx)] == $past(w_data_q[0]) && bvalid_q)
		else $error("polarity write not applied at once");

	// a held address or data word blocks the next one until it is committed
	AST_AW_HELD: assert property (@(posedge CLK_SYS) disable iff (RST) // R3
		aw_held_q |-> !S_AXI_AWREADY)
		else $error("address taken while one is held");
	AST_W_HELD: assert property (@(posedge CLK_SYS) disable iff (RST) // R3
		w_held_q |-> !S_AXI_WREADY)
		else $error("data taken while one is held");

	// the read side answers one address at a time, and strange places decode to an error
	AST_ONE_READ: assert property (@(posedge CLK_SYS) disable iff (RST) // R3
		S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read address taken while an answer stands");
	AST_DECODE_ERROR: assert property (@(posedge CLK_SYS) disable iff (RST) // R2
		s_rd(12'h200) |=> S_AXI_RVALID && S_AXI_RRESP == vout_cfg_pkg::RESP_DEC && S_AXI_RDATA == 32'h0000_0000)
		else $error("unmapped read not refused");
endmodule

// ==== bench/virtual_output_config_bank_tb.sv ====
// self-checking testbench of the virtual output configuration bank
`timescale 1ns/100ps
module virtual_output_config_bank_tb;
	// ------------------------------------------------------------
	// signals and reference state
	// ------------------------------------------------------------
	logic        CLK_SYS = 1'b0;
	logic        RST     = 1'b1;
	logic [99:0] FUNC_STATE = '0;
	logic [17:0] level;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata  = '0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb = 4'hF;
	logic [17:0] lv;
	int          seed = 87248, miscompares = 0, checked = 0, cycles = 0;
	logic [6:0]  fn_m [18];
	logic        pol_m [18];
	logic [1:0]  bq [$];
	logic [33:0] rq [$];

	vout_cfg_bank #(.NUM_FUNC(100)) u_vout_cfg_bank (.CLK_SYS(CLK_SYS), .RST(RST), .FUNC_STATE(FUNC_STATE),
		.VIRTUAL_OUTPUT_LEVEL(level), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

	// free-running 125 MHz clock
	initial begin
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// write: address and data offered together, each dropped at its own handshake
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		bit aw_done = 0, w_done = 0;
		bq.push_back(r);
		@(posedge CLK_SYS);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge CLK_SYS);
			if (awready && !aw_done) begin
				awvalid <= 1'b0;
				aw_done = 1;
			end
			if (wready && !w_done) begin
				wvalid <= 1'b0;
				w_done = 1;
			end
		end
		do @(posedge CLK_SYS); while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge CLK_SYS);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge CLK_SYS); while (!arready);
		arvalid <= 1'b0;
		do @(posedge CLK_SYS); while (!rvalid);
		rready <= 1'b0;
	endtask

	// polarity applied on top of the selected function state
	function automatic logic [17:0] lvl_exp();
		logic [17:0] v;
		for (int i = 0; i < 18; i++) v[i] = FUNC_STATE[fn_m[i]] ^ pol_m[i];
		return v;
	endfunction

	// ------------------------------------------------------------
	// answer monitor and timeout
	// ------------------------------------------------------------
	// answers are paired with the oldest note, since only one of each kind is under way
	always @(posedge CLK_SYS) begin
		if (!RST && bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()}, "write answer");
		if (!RST && rvalid && rready) check({rresp, rdata}, rq.pop_front(), "read answer");
	end

	always @(posedge CLK_SYS) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge CLK_SYS);
		RST <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		// every setting of all eighteen outputs starts at zero
		for (int k = 0; k < 18; k++) begin
			fn_m[k] = 7'h00;
			pol_m[k] = 1'b0;
			rd(vout_cfg_pkg::FN_BASE + 12'(4 * k), 34'h0);
			rd(vout_cfg_pkg::POL_BASE + 12'(4 * k), 34'h0);
		end
		$display("test defaults done");
		// codes in range, both ends included, take effect and read back
		for (int k = 0; k < 18; k++) begin
			fn_m[k] = (k == 0) ? 7'd99 : (k == 17) ? 7'd0 : 7'($unsigned($random(seed)) % 100);
			pol_m[k] = 1'($random(seed));
			wr(vout_cfg_pkg::FN_BASE + 12'(4 * k), {25'h0, fn_m[k]}, vout_cfg_pkg::RESP_OKAY);
			wr(vout_cfg_pkg::POL_BASE + 12'(4 * k), {31'h0, pol_m[k]}, vout_cfg_pkg::RESP_OKAY);
			rd(vout_cfg_pkg::FN_BASE + 12'(4 * k), {2'h0, 25'h0, fn_m[k]});
			rd(vout_cfg_pkg::POL_BASE + 12'(4 * k), {2'h0, 31'h0, pol_m[k]});
		end
		// code 100 lies outside the range and must leave the setting alone
		wr(vout_cfg_pkg::FN_BASE + 12'h00C, 32'h64, vout_cfg_pkg::RESP_SLV);
		rd(vout_cfg_pkg::FN_BASE + 12'h00C, {2'h0, 25'h0, fn_m[3]});
		// lanes that are off keep their bytes; polarity ignores a write without lane 0
		wstrb <= 4'h0;
		wr(vout_cfg_pkg::POL_BASE + 12'h008, {31'h0, !pol_m[2]}, vout_cfg_pkg::RESP_OKAY);
		rd(vout_cfg_pkg::POL_BASE + 12'h008, {2'h0, 31'h0, pol_m[2]});
		wstrb <= 4'h1;
		fn_m[2] = 7'h05;
		wr(vout_cfg_pkg::FN_BASE + 12'h008, 32'h0000_FF05, vout_cfg_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		rd(vout_cfg_pkg::FN_BASE + 12'h008, {2'h0, 25'h0, fn_m[2]});
		$display("test settings done");
		// random function states seen through polarity at the port and in both level words
		for (int n = 0; n < 4; n++) begin
			@(posedge CLK_SYS);
			FUNC_STATE <= 100'({$random(seed), $random(seed), $random(seed), $random(seed)});
			repeat (3) @(posedge CLK_SYS);
			lv = lvl_exp();
			check({16'h0, level}, {16'h0, lv}, "level port");
			rd(vout_cfg_pkg::LVL_LO_ADR, {2'h0, 16'h0, lv[15:0]});
			rd(vout_cfg_pkg::LVL_HI_ADR, {2'h0, 30'h0, lv[17:16]});
		end
		// level words refuse writes; unmapped and misaligned places decode to an error
		wr(vout_cfg_pkg::LVL_LO_ADR, 32'hFFFF, vout_cfg_pkg::RESP_SLV);
		wr(vout_cfg_pkg::LVL_HI_ADR, 32'h3, vout_cfg_pkg::RESP_SLV);
		rd(12'h200, {vout_cfg_pkg::RESP_DEC, 32'h0});
		rd(12'h002, {vout_cfg_pkg::RESP_DEC, 32'h0});
		$display("test levels done");
		// a reset in mid-run brings every setting back to zero
		RST <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		RST <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		for (int k = 0; k < 18; k++) begin
			fn_m[k] = 7'h00;
			pol_m[k] = 1'b0;
		end
		lv = lvl_exp();
		check({16'h0, level}, {16'h0, lv}, "level after reset");
		rd(vout_cfg_pkg::FN_BASE + 12'h044, 34'h0);
		rd(vout_cfg_pkg::POL_BASE + 12'h000, 34'h0);
		$display("test reset done");
		repeat (4) @(posedge CLK_SYS);
		check(34'(bq.size() + rq.size()), 34'h0, "notes left over");
		stop_test();
	end
endmodule
